// ==== hdl/uie_top.sv ====
// Chosen here: the APB interface to the registers.
`include "uie_regs.svh"

module uie_top (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // interrupt sources from the uart core
  input wire logic RX_TRIG_REACHED,
  input wire logic RX_FIFO_NONEMPTY,
  input wire logic RX_FIFO_ACTIVITY,
  input wire logic HALF_CHAR_TICK,
  input wire logic THR_EMPTY,
  input wire logic [3:0] RX_LINE_ERR,
  input wire logic [3:0] MODEM_DELTA,
  input wire logic AUTOBAUD_TIMEOUT,
  input wire logic AUTOBAUD_DONE,
  // control seen by the uart core
  output logic DIVISOR_LATCH_ACCESS,
  output logic AUTO_CTS_EN,
  output logic [7:0] DIVISOR_HIGH,
  // interrupt outputs
  output logic UART_IRQ,
  output logic INT
);
  import uie_pkg::*;

  // ==========================================================
  // bus decode
  logic setup_ok; // access phase of a transfer
  logic wr_en; // write strobe at the completing edge
  logic hit_ier; // enable register selected
  logic hit_dlm; // divisor high byte selected
  logic hit_iir;
  logic hit_lsr;
  logic hit_msr;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_mask;
  logic mapped; // any legal address

  // ==========================================================
  // state
  uie_irq_vec_t uart_irq_enable_reg; // enable bits
  uie_irq_vec_t uart_irq_enable_next;
  logic [1:0] ctrl_reg; // divisor latch access, auto-cts
  logic [7:0] dlm_reg; // divisor latch high byte
  uie_irq_vec_t stat_reg; // sticky event bits
  uie_irq_vec_t stat_next;
  uie_irq_vec_t mask_reg; // interrupt mask
  logic [3:0] tmo_cnt_reg; // idle half-characters
  logic tmo_reg; // time-out source level
  logic abto_seen_reg; // auto-baud time-out event held
  logic abeo_seen_reg; // auto-baud done event held
  logic [31:0] rdata_next;

  // ==========================================================
  // gated sources
  logic rxdata_gated;
  logic tmo_gated;
  logic txempty_gated;
  logic lineerr_gated;
  logic modem_src; // modem source with cts qualification
  logic modem_gated;
  logic autobaud_timeout_flag;
  logic autobaud_done_flag;
  uie_irq_vec_t gated; // gated sources in enable layout
  uie_id_t irq_id; // current identification code

  // true for an access to a given register
  function automatic logic sel(input logic [31:0] a, input logic [31:0] b);
    sel = (a == b);
  endfunction : sel

  // ==========================================================
  // apb decode, zero wait states
  assign setup_ok = PSEL && PENABLE;
  assign PREADY = 1'b1;
  // the shared address reaches the enable register only when latch access is 0
  assign hit_ier = sel(PADDR, `UIE_IER_ADDR) && !ctrl_reg[`UIE_CTRL_DLA];
  assign hit_dlm = sel(PADDR, `UIE_IER_ADDR) && ctrl_reg[`UIE_CTRL_DLA];
  assign hit_iir = sel(PADDR, `UIE_IIR_ADDR);
  assign hit_lsr = sel(PADDR, `UIE_LSR_ADDR);
  assign hit_msr = sel(PADDR, `UIE_MSR_ADDR);
  assign hit_ctrl = sel(PADDR, `UIE_CTRL_ADDR);
  assign hit_stat = sel(PADDR, `UIE_STAT_ADDR);
  assign hit_mask = sel(PADDR, `UIE_MASK_ADDR);
  assign mapped = hit_ier || hit_dlm || hit_iir || hit_lsr || hit_msr
    || hit_ctrl || hit_stat || hit_mask;
  // unmapped addresses answer with an error and change nothing
  assign PSLVERR = setup_ok && !mapped;
  assign wr_en = setup_ok && PWRITE && mapped;

  // ==========================================================
  // control register and divisor high byte
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctrl_reg <= `UIE_CTRL_RESET;
    end else if (wr_en && hit_ctrl) begin
      ctrl_reg <= PWDATA[1:0];
    end
  end

  // divisor byte shares the enable address while latch access is 1
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      dlm_reg <= `UIE_DLM_RESET;
    end else if (wr_en && hit_dlm) begin
      dlm_reg <= PWDATA[7:0];
    end
  end

  assign DIVISOR_LATCH_ACCESS = ctrl_reg[`UIE_CTRL_DLA];
  assign AUTO_CTS_EN = ctrl_reg[`UIE_CTRL_ACTS];
  assign DIVISOR_HIGH = dlm_reg;

  // ==========================================================
  // enable register; reserved bits 6:4 are never stored, so
  // whatever software writes there cannot reach the gating
  always_comb begin
    uart_irq_enable_next = uart_irq_enable_reg;
    if (wr_en && hit_ier) begin
      uart_irq_enable_next = PWDATA[9:0] & `UIE_IER_WMASK;
    end
  end

  // all sources blocked after reset
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      uart_irq_enable_reg <= `UIE_IER_RESET;
    end else begin
      uart_irq_enable_reg <= uart_irq_enable_next;
    end
  end

  // ==========================================================
  // character time-out: count half-character ticks while data
  // waits; 8 halves sits in the middle of the allowed window
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      tmo_cnt_reg <= 4'h0;
    end else if (RX_FIFO_ACTIVITY || !RX_FIFO_NONEMPTY) begin
      tmo_cnt_reg <= 4'h0;
    end else if (HALF_CHAR_TICK && (tmo_cnt_reg != `UIE_TMO_HALF_CHARS)) begin
      tmo_cnt_reg <= tmo_cnt_reg + 4'h1;
    end
  end

  // level source, dropped by any fifo activity
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      tmo_reg <= 1'b0;
    end else if (RX_FIFO_ACTIVITY || !RX_FIFO_NONEMPTY) begin
      tmo_reg <= 1'b0;
    end else if (tmo_cnt_reg == `UIE_TMO_HALF_CHARS) begin
      tmo_reg <= 1'b1;
    end
  end

  // ==========================================================
  // auto-baud events are pulses; hold them until software clears
  // the status bit, and a new event in the clear cycle wins
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      abto_seen_reg <= 1'b0;
    end else if (AUTOBAUD_TIMEOUT) begin
      abto_seen_reg <= 1'b1;
    end else if (wr_en && hit_stat && PWDATA[`UIE_IER_ABTO]) begin
      abto_seen_reg <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      abeo_seen_reg <= 1'b0;
    end else if (AUTOBAUD_DONE) begin
      abeo_seen_reg <= 1'b1;
    end else if (wr_en && hit_stat && PWDATA[`UIE_IER_ABEO]) begin
      abeo_seen_reg <= 1'b0;
    end
  end

  // ==========================================================
  // source gating, each enable one means permitted
  assign rxdata_gated = RX_TRIG_REACHED && uart_irq_enable_reg[`UIE_IER_RXDATA];
  assign tmo_gated = tmo_reg && uart_irq_enable_reg[`UIE_IER_RXDATA];
  assign txempty_gated = THR_EMPTY && uart_irq_enable_reg[`UIE_IER_TXEMPTY];
  assign lineerr_gated = (|RX_LINE_ERR) && uart_irq_enable_reg[`UIE_IER_LINEERR];
  // cts change counts only with bit 7 in auto-cts mode
  assign modem_src = (|MODEM_DELTA[3:1])
    || (MODEM_DELTA[0] && (!ctrl_reg[`UIE_CTRL_ACTS]
    || uart_irq_enable_reg[`UIE_IER_CTS]));
  assign modem_gated = modem_src && uart_irq_enable_reg[`UIE_IER_MODEM];
  assign autobaud_timeout_flag = abto_seen_reg
    && uart_irq_enable_reg[`UIE_IER_ABTO];
  assign autobaud_done_flag = abeo_seen_reg
    && uart_irq_enable_reg[`UIE_IER_ABEO];

  // gated sources laid out as the enable register
  always_comb begin
    gated = '0;
    gated[`UIE_IER_RXDATA] = rxdata_gated || tmo_gated;
    gated[`UIE_IER_TXEMPTY] = txempty_gated;
    gated[`UIE_IER_LINEERR] = lineerr_gated;
    gated[`UIE_IER_MODEM] = modem_gated;
    gated[`UIE_IER_ABTO] = autobaud_timeout_flag;
    gated[`UIE_IER_ABEO] = autobaud_done_flag;
  end

  // combinational from the enable flops, so it follows a write next cycle
  assign UART_IRQ = |gated;

  // ==========================================================
  // identification code, fixed priority
  always_comb begin
    if (lineerr_gated) begin
      irq_id = UIE_ID_LINEERR;
    end else if (rxdata_gated) begin
      irq_id = UIE_ID_RXDATA;
    end else if (tmo_gated) begin
      irq_id = UIE_ID_TIMEOUT;
    end else if (txempty_gated) begin
      irq_id = UIE_ID_TXEMPTY;
    end else begin
      irq_id = UIE_ID_MODEM; // also shown when nothing pends
    end
  end

  // ==========================================================
  // sticky status: set by gated sources, write one to clear;
  // set wins over a clear in the same cycle
  always_comb begin
    stat_next = stat_reg;
    if (wr_en && hit_stat) begin
      stat_next = stat_reg & ~PWDATA[9:0];
    end
    stat_next = stat_next | gated;
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // mask of the same layout; one lets the bit reach INT
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      mask_reg <= '0;
    end else if (wr_en && hit_mask) begin
      mask_reg <= PWDATA[9:0] & `UIE_IER_WMASK;
    end
  end

  assign INT = |(stat_reg & mask_reg);

  // ==========================================================
  // read mux; reserved bits read as zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (hit_ier) begin
      rdata_next[9:0] = uart_irq_enable_reg;
    end else if (hit_dlm) begin
      rdata_next[7:0] = dlm_reg;
    end else if (hit_iir) begin
      rdata_next[`UIE_IIR_PEND_N] = !(|gated[3:0]);
      rdata_next[3:1] = irq_id;
      rdata_next[`UIE_IIR_ABEO] = autobaud_done_flag;
      rdata_next[`UIE_IIR_ABTO] = autobaud_timeout_flag;
    end else if (hit_lsr) begin
      // raw conditions stay visible whatever the enables say
      rdata_next[5] = THR_EMPTY;
      rdata_next[4:1] = RX_LINE_ERR;
      rdata_next[0] = RX_FIFO_NONEMPTY;
    end else if (hit_msr) begin
      rdata_next[3:0] = MODEM_DELTA;
    end else if (hit_ctrl) begin
      rdata_next[1:0] = ctrl_reg;
    end else if (hit_stat) begin
      rdata_next[9:0] = stat_reg;
    end else if (hit_mask) begin
      rdata_next[9:0] = mask_reg;
    end
  end

  // read data registered in the setup cycle, valid in the access phase
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= rdata_next;
    end
  end

endmodule : uie_top

// ==== common/uie_regs.svh ====
`ifndef UIE_REGS_SVH
`define UIE_REGS_SVH
// ==========================================================
// register byte addresses
`define UIE_IER_ADDR 32'hE001_0004
`define UIE_IIR_ADDR 32'hE001_0008
`define UIE_LSR_ADDR 32'hE001_0014
`define UIE_MSR_ADDR 32'hE001_0018
`define UIE_CTRL_ADDR 32'hE001_0040
`define UIE_STAT_ADDR 32'hE001_0044
`define UIE_MASK_ADDR 32'hE001_0048
// ==========================================================
// enable register fields
`define UIE_IER_RXDATA 0
`define UIE_IER_TXEMPTY 1
`define UIE_IER_LINEERR 2
`define UIE_IER_MODEM 3
`define UIE_IER_CTS 7
`define UIE_IER_ABTO 8
`define UIE_IER_ABEO 9
`define UIE_IER_WMASK 10'h38F
`define UIE_IER_RESET 10'h000
// ==========================================================
// control register fields
`define UIE_CTRL_DLA 0
`define UIE_CTRL_ACTS 1
`define UIE_CTRL_RESET 2'h0
`define UIE_DLM_RESET 8'h00
// ==========================================================
// identification register fields
`define UIE_IIR_PEND_N 0
`define UIE_IIR_ABEO 8
`define UIE_IIR_ABTO 9
// ==========================================================
// character time-out: half-character ticks to wait (4.0 chars)
`define UIE_TMO_HALF_CHARS 4'h8
`endif

// ==== common/uie_pkg.sv ====
// ==========================================================
// shared types of the interrupt-enable block
package uie_pkg;
  // implemented enable and status width (bits 9:0)
  typedef logic [9:0] uie_irq_vec_t;
  // identification codes, highest priority first
  typedef enum logic [2:0] {
    UIE_ID_LINEERR = 3'h3,
    UIE_ID_RXDATA = 3'h2,
    UIE_ID_TIMEOUT = 3'h6,
    UIE_ID_TXEMPTY = 3'h1,
    UIE_ID_MODEM = 3'h0
  } uie_id_t;
endpackage : uie_pkg

// ==== tb/uie_top_sva.sv ====
`include "uie_regs.svh"

// ====
// checker: interrupt gating seen at the ports
module uie_chk (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  // sources
  input wire logic RX_TRIG_REACHED,
  input wire logic THR_EMPTY,
  input wire logic [3:0] RX_LINE_ERR,
  input wire logic [3:0] MODEM_DELTA,
  input wire logic AUTOBAUD_DONE,
  // control and request
  input wire logic DIVISOR_LATCH_ACCESS,
  input wire logic AUTO_CTS_EN,
  input wire logic [7:0] DIVISOR_HIGH,
  input wire logic UART_IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  // shadow of the enable bits, so gating can be judged without the body
  logic [9:0] en_reg;
  wire logic wr_ier = PSEL && PENABLE && PWRITE && PADDR == `UIE_IER_ADDR;
  // shadow follows completed writes while the divisor latch is closed
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      en_reg <= 10'h000;
    end else if (wr_ier && !DIVISOR_LATCH_ACCESS) begin
      en_reg <= PWDATA[9:0] & 10'h38F;
    end
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  AST_ALL_OFF: assert property (en_reg == 10'h000 |-> !UART_IRQ)
    else $error("request with all enables clear");
  AST_DATA: assert property (en_reg[0] && RX_TRIG_REACHED |-> UART_IRQ)
    else $error("data available not raised");
  AST_THR: assert property (en_reg[1] && THR_EMPTY |-> UART_IRQ)
    else $error("holding empty not raised");
  AST_LINE: assert property (en_reg[2] && |RX_LINE_ERR |-> UART_IRQ)
    else $error("line error not raised");
  AST_MODEM: assert property (en_reg[3] && |MODEM_DELTA[3:1] |-> UART_IRQ)
    else $error("modem change not raised");
  AST_CTS_BLOCK: assert property (
    AUTO_CTS_EN && en_reg == 10'h008 && MODEM_DELTA == 4'h1 |-> !UART_IRQ)
    else $error("cts change passed without bit 7");
  AST_CTS_BOTH: assert property (
    AUTO_CTS_EN && en_reg[3] && en_reg[7] && MODEM_DELTA[0] |-> UART_IRQ)
    else $error("cts change blocked in auto mode");
  AST_CTS_NORM: assert property (
    !AUTO_CTS_EN && en_reg[3] && MODEM_DELTA[0] |-> UART_IRQ)
    else $error("cts change blocked in normal mode");
  AST_DONE: assert property (AUTOBAUD_DONE && en_reg[9] |-> ##[0:2] UART_IRQ)
    else $error("auto-baud completion not raised");
  AST_DIV: assert property (
    wr_ier && DIVISOR_LATCH_ACCESS |=> {24'h0, DIVISOR_HIGH} == ($past(PWDATA) & 32'h0000_00FF))
    else $error("divisor byte not written");
  AST_READ: assert property (
    PSEL && PENABLE && !PWRITE && PADDR == `UIE_IER_ADDR && !DIVISOR_LATCH_ACCESS
    |-> PRDATA == {22'h0, en_reg})
    else $error("enable readback wrong");
endmodule : uie_chk

bind uie_top uie_chk u_chk (.CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .RX_TRIG_REACHED(RX_TRIG_REACHED), .THR_EMPTY(THR_EMPTY), .RX_LINE_ERR(RX_LINE_ERR),
  .MODEM_DELTA(MODEM_DELTA), .AUTOBAUD_DONE(AUTOBAUD_DONE),
  .DIVISOR_LATCH_ACCESS(DIVISOR_LATCH_ACCESS), .AUTO_CTS_EN(AUTO_CTS_EN),
  .DIVISOR_HIGH(DIVISOR_HIGH), .UART_IRQ(UART_IRQ));

// ==== tb/uie_top_tb_top.sv ====
`include "uie_regs.svh"

// ====
// bench: table of gating cases, then hand-written cases
module uie_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // one gating case: enables, mode, sources, expected request
  typedef struct packed {
    logic [9:0] en;
    logic acts;
    logic trig;
    logic thr;
    logic [3:0] err;
    logic [3:0] md;
    logic irq;
  } uie_row_t;
  uie_row_t rows [10] = '{
    '{10'h000, 1'h0, 1'h1, 1'h1, 4'hF, 4'hF, 1'h0},
    '{10'h001, 1'h0, 1'h1, 1'h0, 4'h0, 4'h0, 1'h1},
    '{10'h00E, 1'h0, 1'h1, 1'h0, 4'h0, 4'h0, 1'h0},
    '{10'h002, 1'h0, 1'h0, 1'h1, 4'h0, 4'h0, 1'h1},
    '{10'h004, 1'h0, 1'h0, 1'h0, 4'h8, 4'h0, 1'h1},
    '{10'h008, 1'h0, 1'h0, 1'h0, 4'h0, 4'h4, 1'h1},
    '{10'h008, 1'h0, 1'h0, 1'h0, 4'h0, 4'h1, 1'h1},
    '{10'h008, 1'h1, 1'h0, 1'h0, 4'h0, 4'h1, 1'h0},
    '{10'h088, 1'h1, 1'h0, 1'h0, 4'h0, 4'h1, 1'h1},
    '{10'h387, 1'h1, 1'h0, 1'h0, 4'h0, 4'h1, 1'h0}};
  // stimulus, all defined at time zero
  logic clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0;
  logic trig = 1'h0, nemp = 1'h0, act = 1'h0, tick = 1'h0, thr = 1'h0;
  logic abto = 1'h0, abdn = 1'h0;
  logic [3:0] err = 4'h0, md = 4'h0;
  // observed outputs and last bus answer
  logic [31:0] prdata, rdata;
  logic pready, pslverr, rerr, dla, acts, irq, intr;
  logic [7:0] divh;
  int err_count = 0;
  int checks_done = 0;
  always #2.5 clk = ~clk;
  uie_top dut (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RX_TRIG_REACHED(trig), .RX_FIFO_NONEMPTY(nemp), .RX_FIFO_ACTIVITY(act),
    .HALF_CHAR_TICK(tick), .THR_EMPTY(thr), .RX_LINE_ERR(err), .MODEM_DELTA(md),
    .AUTOBAUD_TIMEOUT(abto), .AUTOBAUD_DONE(abdn), .DIVISOR_LATCH_ACCESS(dla),
    .AUTO_CTS_EN(acts), .DIVISOR_HIGH(divh), .UART_IRQ(irq), .INT(intr));
  // ====
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; an idle edge first so no signal is set twice in a step
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    // wait as long as the slave needs; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rdata, e);
  endtask : rd
  // one-cycle pulse: 0 tick, 1 fifo activity, 2 auto-baud time-out, 3 auto-baud done
  task automatic pulse(input logic [1:0] which);
    tick <= (which == 2'h0);
    act <= (which == 2'h1);
    abto <= (which == 2'h2);
    abdn <= (which == 2'h3);
    @(posedge clk);
    {tick, act, abto, abdn} <= 4'h0;
    @(posedge clk);
  endtask : pulse
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  // ====
  // watchdog: the whole run needs well under this
  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    rd(`UIE_IER_ADDR, 32'h0);
    chk({31'h0, irq}, 32'h0);
    foreach (rows[i]) begin
      trig <= rows[i].trig;
      thr <= rows[i].thr;
      err <= rows[i].err;
      md <= rows[i].md;
      wr(`UIE_CTRL_ADDR, {30'h0, rows[i].acts, 1'h0});
      wr(`UIE_IER_ADDR, {22'h0, rows[i].en});
      chk({31'h0, acts}, {31'h0, rows[i].acts});
      rd(`UIE_IER_ADDR, {22'h0, rows[i].en});
      rd(`UIE_LSR_ADDR, {26'h0, rows[i].thr, rows[i].err, 1'h0});
      rd(`UIE_MSR_ADDR, {28'h0, rows[i].md});
      @(posedge clk);
      chk({31'h0, irq}, {31'h0, rows[i].irq});
    end
    // divisor latch open: same address reaches the divisor byte
    wr(`UIE_CTRL_ADDR, 32'h1);
    wr(`UIE_IER_ADDR, 32'hA5);
    chk({31'h0, dla}, 32'h1);
    rd(`UIE_IER_ADDR, 32'hA5);
    chk({24'h0, divh}, 32'hA5);
    wr(`UIE_CTRL_ADDR, 32'h0);
    rd(`UIE_IER_ADDR, 32'h387);
    // idle fifo: eight half-character ticks, request one cycle later
    md <= 4'h0;
    wr(`UIE_IER_ADDR, 32'h1);
    nemp <= 1'h1;
    repeat (7) pulse(2'h0);
    chk({31'h0, irq}, 32'h0);
    pulse(2'h0);
    // the level is registered at the edge that ends the pulse; look one edge later
    @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rd(`UIE_IIR_ADDR, 32'hC);
    pulse(2'h1);
    chk({31'h0, irq}, 32'h0);
    nemp <= 1'h0;
    // auto-baud flags need the event and the enable
    wr(`UIE_IER_ADDR, 32'h100);
    pulse(2'h2);
    chk({31'h0, irq}, 32'h1);
    rd(`UIE_IIR_ADDR, 32'h201);
    wr(`UIE_IER_ADDR, 32'h0);
    rd(`UIE_IIR_ADDR, 32'h1);
    wr(`UIE_STAT_ADDR, 32'h300);
    wr(`UIE_IER_ADDR, 32'h200);
    pulse(2'h3);
    rd(`UIE_IIR_ADDR, 32'h101);
    // identification codes in priority order
    wr(`UIE_IER_ADDR, 32'h7);
    err <= 4'h1;
    trig <= 1'h1;
    thr <= 1'h1;
    rd(`UIE_IIR_ADDR, 32'h6);
    err <= 4'h0;
    rd(`UIE_IIR_ADDR, 32'h4);
    trig <= 1'h0;
    rd(`UIE_IIR_ADDR, 32'h2);
    thr <= 1'h0;
    rd(`UIE_IIR_ADDR, 32'h1);
    wr(`UIE_IER_ADDR, 32'h8);
    md <= 4'h2;
    rd(`UIE_IIR_ADDR, 32'h0);
    md <= 4'h0;
    // sticky status, mask and the level output
    wr(`UIE_STAT_ADDR, 32'h3FF);
    rd(`UIE_STAT_ADDR, 32'h0);
    thr <= 1'h1;
    wr(`UIE_IER_ADDR, 32'h2);
    wr(`UIE_MASK_ADDR, 32'h2);
    @(posedge clk);
    chk({31'h0, intr}, 32'h1);
    wr(`UIE_MASK_ADDR, 32'h0);
    @(posedge clk);
    chk({31'h0, intr}, 32'h0);
    // unmapped address is refused
    rd(32'hE001_00FC, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    // second reset clears the enables again
    @(posedge clk);
    rst <= 1'h1;
    @(posedge clk);
    rst <= 1'h0;
    rd(`UIE_IER_ADDR, 32'h0);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, intr}, 32'h0);
    tally_and_finish();
  end
endmodule : uie_top_tb_top
